// ==== include/rmr_pkg.sv ====
// Constants, types and register map of the repeater mode and rx-detect control
package rmr_pkg;
  localparam int RMR_CLK_KHZ        = 125000;
  localparam int RMR_CLK_NS         = 8;
  localparam int RMR_PROBE_MS       = 12;
  localparam int RMR_PROBE_LIMIT_MS = 600;
  localparam int RMR_PD_RESET_NS    = 5000;
  localparam int RMR_PD_CYC         =
    (RMR_PD_RESET_NS + RMR_CLK_NS - 1) / RMR_CLK_NS;
  localparam int RMR_PROBE_MAX      = RMR_PROBE_LIMIT_MS / RMR_PROBE_MS;

  // Pin states in the same order as the termination register codes
  typedef enum logic [1:0] {LVL_0, LVL_R, LVL_F, LVL_1} rmr_lvl_t;
  typedef enum logic [1:0] {MODE_PIN, MODE_SLAVE, MODE_MASTER} rmr_mode_t;
  typedef enum logic [1:0] {RX_WAIT, RX_FOUND, RX_STOP} rmr_rx_t;

  typedef struct packed {
    logic       term_dis;
    logic [2:0] swing;
    logic [1:0] eq;
  } rmr_chan_t;

  localparam rmr_chan_t RMR_CHAN_RST = '{term_dis: 1'b0, swing: 3'h6,
                                         eq: 2'h2};
  localparam logic [2:0] RMR_SWING_DFLT = 3'h6;
  localparam logic [1:0] RMR_TERM_RST   = 2'h2;
  localparam logic [3:0] RMR_THR_RST    = 4'h0;

  // Register indices; byte address is four times the index
  localparam logic [5:0] RMR_IDX_PRES = 6'h02;
  localparam logic [5:0] RMR_IDX_EN   = 6'h06;
  localparam logic [5:0] RMR_IDX_TERM = 6'h08;
  localparam logic [5:0] RMR_IDX_THR  = 6'h09;
  localparam logic [5:0] RMR_IDX_STAT = 6'h0A;
  localparam logic [5:0] RMR_IDX_CH0  = 6'h10;

  localparam int RMR_PRES_OVR_BIT = 7;
  localparam int RMR_PRES_VAL_BIT = 6;
  localparam int RMR_EN_BIT       = 3;
  localparam int RMR_TERM_LSB     = 2;
  localparam int RMR_TERM_OVR_BIT = 0;
  localparam int RMR_THR_OVR_BIT  = 4;

  // Order of the four-level pins in the decoded vector
  localparam int PIN_MODE = 0;
  localparam int PIN_TERM = 1;
  localparam int PIN_SDTH = 2;
  localparam int PIN_EQA  = 3;
  localparam int PIN_EQB  = 4;
  localparam int PIN_SWA1 = 5;
  localparam int PIN_SWA0 = 6;
  localparam int PIN_SWB1 = 7;
  localparam int PIN_SWB0 = 8;
  localparam int RMR_NPIN = 9;
endpackage

// ==== rtl/rmr_ctrl.sv ====
// Mode select, pin/register arbitration and rx-detect control of the repeater
//
// The implementer's own choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
module rmr_ctrl
  import rmr_pkg::*;
#(
  parameter int CH        = 8,
  parameter int PROBE_CYC = RMR_PROBE_MS * RMR_CLK_KHZ,
  parameter int FILT_DIV  = 125,
  parameter int FILT_N    = 4
) (
  input  wire  logic              clk,
  input  wire  logic              reset,
  input  wire  logic [2:0]        mode_strap,
  input  wire  logic [2:0]        termination_select_pin,
  input  wire  logic [2:0]        sigdet_threshold_pin,
  input  wire  logic [5:0]        equalizer_level_pins,
  input  wire  logic [11:0]       output_swing_pins,
  input  wire  logic              power_down_pin,
  input  wire  logic              rx_found,
  input  wire  logic [CH-1:0]     sd_assert,
  input  wire  logic [CH-1:0]     sd_deassert,
  input  wire  logic [7:0]        address,
  input  wire  logic [3:0]        byteenable,
  input  wire  logic              read,
  input  wire  logic              write,
  input  wire  logic [31:0]       writedata,
  output logic [31:0]             readdata,
  output logic                    waitrequest,
  output rmr_mode_t               op_mode,
  output logic [3:0]              bus_address_straps,
  output logic [CH*2-1:0]         eq_setting,
  output logic [CH*3-1:0]         output_swing,
  output logic [CH-1:0]           input_term_50,
  output logic                    drivers_disable,
  output logic                    probe_pulse,
  output logic [1:0]              sd_assert_level,
  output logic [1:0]              sd_deassert_level
);
  localparam int AW  = 3 * RMR_NPIN + 2 + 2 * CH;
  localparam int PCW = $clog2(PROBE_CYC);
  localparam int PNW = $clog2(RMR_PROBE_MAX);
  localparam int PDW = $clog2(RMR_PD_CYC + 1);
  localparam int FDW = $clog2(FILT_DIV);
  localparam int FNW = $clog2(FILT_N);
  localparam int CHW = $clog2(CH);

  function automatic rmr_lvl_t lvl_dec(input logic [2:0] t);
    if (t[2]) return LVL_1;
    else if (t[1]) return LVL_F;
    else if (t[0]) return LVL_R;
    else return LVL_0;
  endfunction

  function automatic logic [1:0] thr_code(input logic [1:0] s);
    case (s)
      LVL_0:   return 2'h2;
      LVL_R:   return 2'h1;
      LVL_F:   return 2'h0;
      default: return 2'h3;
    endcase
  endfunction

  function automatic logic [2:0] swing_dec(input logic [1:0] hi,
                                           input logic [1:0] lo);
    case ({hi, lo})
      {LVL_0, LVL_0}: return 3'h1;
      {LVL_0, LVL_R}: return 3'h2;
      {LVL_0, LVL_1}: return 3'h3;
      {LVL_R, LVL_F}: return 3'h4;
      {LVL_F, LVL_R}: return 3'h5;
      {LVL_1, LVL_0}: return 3'h6;
      default:        return RMR_SWING_DFLT;
    endcase
  endfunction

  logic [AW-1:0] s1_reg, s2_reg, s3_reg, clean_reg, clean_next;
  wire  [AW-1:0] a_in = {sd_deassert, sd_assert, rx_found, power_down_pin,
                         output_swing_pins, equalizer_level_pins,
                         sigdet_threshold_pin, termination_select_pin,
                         mode_strap};
  // A bit counts only once the second and third stage agree
  assign clean_next = (s2_reg & ~(s2_reg ^ s3_reg))
                    | (clean_reg & (s2_reg ^ s3_reg));
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s1_reg    <= '0;
      s2_reg    <= '0;
      s3_reg    <= '0;
      clean_reg <= '0;
    end else begin
      s1_reg    <= a_in;
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      clean_reg <= clean_next;
    end
  end
  wire pd     = clean_reg[3*RMR_NPIN];
  wire rx_hit = clean_reg[3*RMR_NPIN+1];
  wire [2*CH-1:0] sd_stat = clean_reg[AW-1:3*RMR_NPIN+2];

  logic [RMR_NPIN-1:0][1:0] dec;
  always_comb begin
    for (int p = 0; p < RMR_NPIN; p++) dec[p] = lvl_dec(clean_reg[3*p +: 3]);
  end

  // Slow sample tick for the glitch filter
  logic [FDW-1:0] div_reg;
  wire tick = (div_reg == FDW'(FILT_DIV - 1));
  always_ff @(posedge clk or posedge reset) begin
    if (reset) div_reg <= '0;
    else div_reg <= tick ? '0 : div_reg + 1'b1;
  end

  // state must hold FILT_N ticks before it is taken
  logic [RMR_NPIN-1:0][1:0]     filt_reg, cand_reg;
  logic [RMR_NPIN-1:0][FNW-1:0] fcnt_reg;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      filt_reg <= {RMR_NPIN{LVL_F}};
      cand_reg <= {RMR_NPIN{LVL_F}};
      fcnt_reg <= '0;
    end else if (tick) begin
      for (int p = 0; p < RMR_NPIN; p++) begin
        if (dec[p] != cand_reg[p]) begin
          cand_reg[p] <= dec[p];
          fcnt_reg[p] <= '0;
        end else if (fcnt_reg[p] == FNW'(FILT_N - 1)) begin
          filt_reg[p] <= cand_reg[p];
        end else begin
          fcnt_reg[p] <= fcnt_reg[p] + 1'b1;
        end
      end
    end
  end

  // mode from strap; unfiltered so the switch is immediate
  wire rmr_mode_t mode_now = (dec[PIN_MODE] == LVL_1) ? MODE_SLAVE :
                             (dec[PIN_MODE] == LVL_F) ? MODE_MASTER : MODE_PIN;
  // No EEPROM loader here, so master mode falls back to register control
  wire use_regs = (mode_now != MODE_PIN);

  // Avalon slave: one wait state, read data staged before it drops
  logic        ack_reg, en_reg, pres_ovr_reg, pres_val_reg, pres_d_reg;
  logic        term_ovr_reg, thr_ovr_reg;
  logic [1:0]  term_code_reg;
  logic [3:0]  thr_reg;
  rmr_chan_t   chan_reg [CH];
  logic [31:0] rd_reg;
  rmr_rx_t     rx_state_reg;
  wire  [5:0]  idx    = address[7:2];
  wire  [5:0]  ch_off = idx - RMR_IDX_CH0;
  wire         is_ch  = (idx >= RMR_IDX_CH0) && (ch_off < 6'(CH));
  wire [CHW-1:0] ch_sel = ch_off[CHW-1:0];
  wire wr_ok = write && !waitrequest && byteenable[0];
  wire set_ok = wr_ok && en_reg;
  assign waitrequest = (read || write) && !ack_reg;
  assign readdata    = rd_reg;

  wire [31:0] rd_mux =
    (idx == RMR_IDX_PRES) ? 32'({pres_ovr_reg, pres_val_reg, 6'h00}) :
    (idx == RMR_IDX_EN)   ? 32'({en_reg, 3'h0}) :
    (idx == RMR_IDX_TERM) ? 32'({term_code_reg, 1'b0, term_ovr_reg}) :
    (idx == RMR_IDX_THR)  ? 32'({thr_ovr_reg, thr_reg}) :
    (idx == RMR_IDX_STAT) ? 32'({mode_now, rx_state_reg, sd_stat}) :
    is_ch                 ? 32'(chan_reg[ch_sel]) : 32'h0000_0000;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ack_reg <= 1'b0;
      rd_reg  <= '0;
    end else begin
      ack_reg <= (read || write) && !ack_reg;
      if (read && !ack_reg) rd_reg <= rd_mux;
    end
  end

  // register writes never look at power-down
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      en_reg        <= 1'b0;
      pres_ovr_reg  <= 1'b0;
      pres_val_reg  <= 1'b0;
      term_ovr_reg  <= 1'b0;
      term_code_reg <= RMR_TERM_RST;
      thr_ovr_reg   <= 1'b0;
      thr_reg       <= RMR_THR_RST;
      for (int c = 0; c < CH; c++) chan_reg[c] <= RMR_CHAN_RST;
    end else begin
      if (wr_ok && idx == RMR_IDX_EN) en_reg <= writedata[RMR_EN_BIT];
      if (set_ok && idx == RMR_IDX_PRES) begin
        pres_ovr_reg <= writedata[RMR_PRES_OVR_BIT];
        pres_val_reg <= writedata[RMR_PRES_VAL_BIT];
      end
      if (set_ok && idx == RMR_IDX_TERM) begin
        term_ovr_reg  <= writedata[RMR_TERM_OVR_BIT];
        term_code_reg <= writedata[RMR_TERM_LSB +: 2];
      end
      if (set_ok && idx == RMR_IDX_THR) begin
        thr_ovr_reg <= writedata[RMR_THR_OVR_BIT];
        thr_reg     <= writedata[3:0];
      end
      if (set_ok && is_ch) chan_reg[ch_sel] <= rmr_chan_t'(writedata[5:0]);
    end
  end

  // toggle of presence value under override restarts detection in bus mode
  always_ff @(posedge clk or posedge reset) begin
    if (reset) pres_d_reg <= 1'b0;
    else pres_d_reg <= pres_val_reg;
  end
  wire restart_sw = use_regs && pres_ovr_reg && (pres_val_reg != pres_d_reg);

  // pin unless overridden in bus mode
  wire [1:0] term_code = (use_regs && term_ovr_reg) ? term_code_reg :
                                                       filt_reg[PIN_TERM];
  wire [3:0] thr_sel = (use_regs && thr_ovr_reg) ? thr_reg :
                       {2{thr_code(filt_reg[PIN_SDTH])}};
  wire auto_det = (term_code == LVL_R) || (term_code == LVL_F);

  // power-down held 5 us resets detection once
  logic [PDW-1:0] pd_cnt_reg;
  wire pd_hold = pd && (pd_cnt_reg == PDW'(RMR_PD_CYC - 1));
  always_ff @(posedge clk or posedge reset) begin
    if (reset) pd_cnt_reg <= '0;
    else if (!pd) pd_cnt_reg <= '0;
    else if (pd_cnt_reg != PDW'(RMR_PD_CYC)) pd_cnt_reg <= pd_cnt_reg + 1'b1;
  end

  logic [PCW-1:0] per_reg;
  logic [PNW-1:0] probes_reg;
  wire restart = pd_hold || restart_sw;
  wire probe_now = (rx_state_reg == RX_WAIT) && auto_det && !pd && !restart
                && (per_reg == PCW'(PROBE_CYC - 1));
  // probe period, limit only in state R
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_state_reg <= RX_WAIT;
      per_reg      <= '0;
      probes_reg   <= '0;
    end else if (restart) begin
      rx_state_reg <= RX_WAIT;
      per_reg      <= '0;
      probes_reg   <= '0;
    end else if (pd || !auto_det) begin
      per_reg <= '0;
    end else begin
      case (rx_state_reg)
        RX_WAIT: begin
          if (!probe_now) begin
            per_reg <= per_reg + 1'b1;
          end else begin
            per_reg <= '0;
            if (rx_hit) rx_state_reg <= RX_FOUND;
            else if (term_code == LVL_R
                     && probes_reg == PNW'(RMR_PROBE_MAX - 1))
              rx_state_reg <= RX_STOP;
            else probes_reg <= probes_reg + 1'b1;
          end
        end
        RX_FOUND: rx_state_reg <= RX_FOUND;
        RX_STOP:  rx_state_reg <= RX_STOP;
        default:  rx_state_reg <= RX_WAIT;
      endcase
    end
  end

  wire term_on = !pd && ((term_code == LVL_1)
               || (auto_det && rx_state_reg == RX_FOUND));

  // Registered outputs
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      op_mode            <= MODE_PIN;
      bus_address_straps <= '0;
      eq_setting         <= '0;
      output_swing       <= '0;
      input_term_50      <= '0;
      drivers_disable    <= 1'b1;
      probe_pulse        <= 1'b0;
      sd_assert_level    <= '0;
      sd_deassert_level  <= '0;
    end else begin
      op_mode         <= mode_now;
      drivers_disable <= pd;
      probe_pulse     <= probe_now;
      sd_assert_level   <= thr_sel[3:2];
      sd_deassert_level <= thr_sel[1:0];
      bus_address_straps <= use_regs ?
        {filt_reg[PIN_SWB1] == LVL_1, filt_reg[PIN_SWA1] == LVL_1,
         filt_reg[PIN_EQB] == LVL_1, filt_reg[PIN_EQA] == LVL_1} : 4'h0;
      for (int c = 0; c < CH; c++) begin
        input_term_50[c] <= term_on && !(use_regs && chan_reg[c].term_dis);
        if (use_regs) begin
          eq_setting[2*c +: 2]   <= chan_reg[c].eq;
          output_swing[3*c +: 3] <= chan_reg[c].swing;
        end else if (c < CH / 2) begin
          eq_setting[2*c +: 2]   <= filt_reg[PIN_EQA];
          output_swing[3*c +: 3] <= swing_dec(filt_reg[PIN_SWA1],
                                              filt_reg[PIN_SWA0]);
        end else begin
          eq_setting[2*c +: 2]   <= filt_reg[PIN_EQB];
          output_swing[3*c +: 3] <= swing_dec(filt_reg[PIN_SWB1],
                                              filt_reg[PIN_SWB0]);
        end
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_grp;
    // Release edge still loads reset values, so skip it
    !reset && !use_regs |=> eq_setting[1:0] == $past(filt_reg[PIN_EQA]);
  endproperty
  a_grp: assert property (p_grp) else $error("group eq wrong");
  property p_src;
    use_regs |=> eq_setting[1:0] == $past(chan_reg[0].eq);
  endproperty
  a_src: assert property (p_src) else $error("reg eq not used");
  property p_regen;
    !en_reg && wr_ok |=> $stable(chan_reg[0]) && $stable(thr_reg);
  endproperty
  a_regen: assert property (p_regen) else $error("write w/o enable");
  property p_pd;
    pd |=> input_term_50 == '0 && drivers_disable;
  endproperty
  a_pd: assert property (p_pd) else $error("power-down not obeyed");
  property p_hiz;
    !pd && term_code == LVL_0 |=> input_term_50 == '0;
  endproperty
  a_hiz: assert property (p_hiz) else $error("hi-z not held");
  property p_50;
    !pd && term_code == LVL_1 && !use_regs |=> &input_term_50;
  endproperty
  a_50: assert property (p_50) else $error("50 ohm missing");
  property p_stop;
    rx_state_reg == RX_STOP |=> !probe_pulse;
  endproperty
  a_stop: assert property (p_stop) else $error("probe after stop");
  property p_pdrst;
    pd_hold |=> rx_state_reg == RX_WAIT && probes_reg == '0;
  endproperty
  a_pdrst: assert property (p_pdrst) else $error("pd reset lost");
  property p_tog;
    restart_sw |=> rx_state_reg == RX_WAIT && per_reg == '0;
  endproperty
  a_tog: assert property (p_tog) else $error("toggle restart lost");
  property p_filt;
    !tick |=> $stable(filt_reg);
  endproperty
  a_filt: assert property (p_filt) else $error("filter off tick");
endmodule
`default_nettype wire

// ==== dv/rmr_board.sv ====
// Board straps and receiver-presence model for the repeater control
`timescale 1ns/10ps
`default_nettype none
module rmr_board
  import rmr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        clr,
  input  wire logic [17:0] lv,
  input  wire logic [7:0]  hit_after,
  input  wire logic        probe_pulse,
  output logic [2:0]       mode_strap,
  output logic [2:0]       termination_select_pin,
  output logic [2:0]       sigdet_threshold_pin,
  output logic [5:0]       equalizer_level_pins,
  output logic [11:0]      output_swing_pins,
  output logic             rx_found
);
  logic [7:0] probe_cnt;

  function automatic logic [2:0] th(input logic [1:0] c);
    th = {c == 2'h3, c >= 2'h2, c != 2'h0};
  endfunction

  assign mode_strap             = th(lv[2*PIN_MODE+:2]);
  assign termination_select_pin = th(lv[2*PIN_TERM+:2]);
  assign sigdet_threshold_pin   = th(lv[2*PIN_SDTH+:2]);
  assign equalizer_level_pins   = {th(lv[2*PIN_EQB+:2]), th(lv[2*PIN_EQA+:2])};
  assign output_swing_pins      = {th(lv[2*PIN_SWB0+:2]), th(lv[2*PIN_SWB1+:2]),
                                   th(lv[2*PIN_SWA0+:2]), th(lv[2*PIN_SWA1+:2])};

  always @(posedge clk) begin
    if (clr)
      probe_cnt <= 8'h00;
    else if (probe_pulse && probe_cnt != 8'hFE)
      probe_cnt <= probe_cnt + 8'h01;
  end
  // All ones in hit_after means no receiver ever
  assign rx_found = (hit_after != 8'hFF) && (probe_cnt >= hit_after);
endmodule
`default_nettype wire

// ==== dv/tb_rmr_ctrl.sv ====
// Self-checking bench for the repeater mode and rx-detect control
`timescale 1ns/10ps
`default_nettype none
module tb_rmr_ctrl
  import rmr_pkg::*;
;
  localparam int CH   = 8;
  localparam int PCYC = 20;
  logic              clk, reset, power_down_pin, rx_found, clr;
  logic              read, write, waitrequest, drivers_disable, probe_pulse;
  logic [2:0]        mode_strap, termination_select_pin, sigdet_threshold_pin;
  logic [5:0]        eqp;
  logic [11:0]       swp;
  logic [CH-1:0]     sd_assert, sd_deassert, input_term_50;
  logic [7:0]        address, hit_after;
  logic [3:0]        byteenable, bus_address_straps;
  logic [31:0]       writedata, readdata, q;
  rmr_mode_t         op_mode;
  logic [CH*2-1:0]   eq_setting;
  logic [CH*3-1:0]   output_swing;
  logic [1:0]        sd_assert_level, sd_deassert_level;
  logic [17:0]       lv;
  logic [1:0]        thr_map [4];
  int                mismatches, total_checks, probes, na, nb;

  rmr_ctrl #(.CH(CH), .PROBE_CYC(PCYC), .FILT_DIV(2), .FILT_N(2)) i_dut (
    .clk(clk), .reset(reset), .mode_strap(mode_strap),
    .termination_select_pin(termination_select_pin),
    .sigdet_threshold_pin(sigdet_threshold_pin),
    .equalizer_level_pins(eqp), .output_swing_pins(swp),
    .power_down_pin(power_down_pin), .rx_found(rx_found),
    .sd_assert(sd_assert), .sd_deassert(sd_deassert), .address(address),
    .byteenable(byteenable), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .op_mode(op_mode), .bus_address_straps(bus_address_straps),
    .eq_setting(eq_setting), .output_swing(output_swing),
    .input_term_50(input_term_50), .drivers_disable(drivers_disable),
    .probe_pulse(probe_pulse), .sd_assert_level(sd_assert_level),
    .sd_deassert_level(sd_deassert_level));

  rmr_board i_board (
    .clk(clk), .clr(clr), .lv(lv), .hit_after(hit_after),
    .probe_pulse(probe_pulse), .mode_strap(mode_strap),
    .termination_select_pin(termination_select_pin),
    .sigdet_threshold_pin(sigdet_threshold_pin),
    .equalizer_level_pins(eqp), .output_swing_pins(swp), .rx_found(rx_found));

  initial clk = 1'b0;
  always #4 clk = ~clk;
  always @(posedge clk) begin
    if (reset)
      probes <= 0;
    else if (probe_pulse === 1'b1)
      probes <= probes + 1;
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Hold the request until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    int n;
    @(posedge clk);
    address    <= a;
    write      <= wr;
    read       <= !wr;
    writedata  <= d;
    byteenable <= be;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (waitrequest === 1'b0) break;
    end
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    if (n == 20) begin
      mismatches++;
      report_and_stop();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask

  task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'hF);
    chk_val(q, exp);
  endtask

  // Pins pass a sync and filter chain before use
  task automatic setp(input int p, input logic [1:0] c);
    @(posedge clk);
    lv[2*p+:2] <= c;
    repeat (40) @(posedge clk);
  endtask

  task automatic chk_term(input logic [CH-1:0] exp);
    chk_val({24'h0, input_term_50}, {24'h0, exp});
  endtask

  initial begin
    reset = 1'b1;
    power_down_pin = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 8'h00;
    writedata = 32'h0;
    byteenable = 4'h0;
    clr = 1'b1;
    hit_after = 8'hFF;
    sd_assert = 8'hA5;
    sd_deassert = 8'h3C;
    mismatches = 0;
    total_checks = 0;
    thr_map = '{2'h2, 2'h1, 2'h0, 2'h3};
    lv = {2'h0, 2'h3, 2'h1, 2'h0, 2'h1, 2'h3, 2'h2, 2'h1, 2'h0};
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    clr <= 1'b0;
    repeat (60 * PCYC) @(posedge clk);
    chk_val(probes, RMR_PROBE_MAX);
    chk_term(8'h00);
    chk_reg(8'h28, 32'h0002_3CA5);
    chk_val(bus_address_straps, 4'h0);
    for (int c = 0; c < 4; c++) begin
      setp(PIN_SDTH, c[1:0]);
      chk_val(sd_assert_level, thr_map[c]);
      chk_val(sd_deassert_level, thr_map[c]);
    end
    chk_reg(8'h20, 32'h8);
    chk_reg(8'h24, 32'h0);
    wr(8'h40, 32'h2D);
    chk_reg(8'h40, 32'h1A);
    wr(8'h18, 32'h8);
    chk_reg(8'h18, 32'h8);
    bus(1'b1, 8'h48, 32'h2D, 4'hE);
    chk_reg(8'h48, 32'h1A);
    wr(8'h48, 32'h2D);
    wr(8'hFC, 32'hFFFF_FFFF);
    chk_reg(8'hFC, 32'h0);
    na = 0;
    nb = 0;
    for (int c = 0; c < CH; c++) begin
      if (eq_setting[2*c+:2] === 2'h3 && output_swing[3*c+:3] === 3'h2) na++;
      if (eq_setting[2*c+:2] === 2'h1 && output_swing[3*c+:3] === 3'h6) nb++;
    end
    chk_val(na, CH / 2);
    chk_val(nb, CH / 2);
    // Auto detect after a long power-down restarts the search
    setp(PIN_TERM, 2'h3);
    chk_term(8'hFF);
    @(posedge clk);
    power_down_pin <= 1'b1;
    clr <= 1'b1;
    hit_after <= 8'h03;
    // Power-down passes the synchroniser before it acts
    repeat (8) @(posedge clk);
    chk_val(drivers_disable, 1'b1);
    chk_term(8'h00);
    setp(PIN_TERM, 2'h2);
    repeat (700) @(posedge clk);
    power_down_pin <= 1'b0;
    clr <= 1'b0;
    chk_reg(8'h48, 32'h2D);
    repeat (2 * PCYC) @(posedge clk);
    chk_term(8'h00);
    chk_val(drivers_disable, 1'b0);
    repeat (8 * PCYC) @(posedge clk);
    chk_term(8'hFF);
    setp(PIN_TERM, 2'h0);
    chk_term(8'h00);
    setp(PIN_TERM, 2'h3);
    chk_term(8'hFF);
    setp(PIN_MODE, 2'h3);
    chk_val(op_mode, MODE_SLAVE);
    chk_val(bus_address_straps, 4'h9);
    chk_val(eq_setting[5:4], 2'h1);
    chk_val(output_swing[8:6], 3'h3);
    chk_val(output_swing[2:0], 3'h6);
    chk_term(8'hFB);
    wr(8'h20, 32'h1);
    repeat (3) @(posedge clk);
    chk_term(8'h00);
    wr(8'h20, 32'hD);
    setp(PIN_TERM, 2'h0);
    chk_term(8'hFB);
    wr(8'h24, 32'h19);
    repeat (3) @(posedge clk);
    chk_val(sd_assert_level, 2'h2);
    chk_val(sd_deassert_level, 2'h1);
    hit_after <= 8'h00;
    wr(8'h20, 32'h9);
    repeat (4 * PCYC) @(posedge clk);
    chk_term(8'hFB);
    chk_reg(8'h28, 32'h0005_3CA5);
    wr(8'h08, 32'h80);
    wr(8'h08, 32'hC0);
    repeat (3) @(posedge clk);
    chk_term(8'h00);
    repeat (3 * PCYC) @(posedge clk);
    chk_term(8'hFB);
    setp(PIN_MODE, 2'h0);
    chk_term(8'h00);
    chk_val(sd_assert_level, 2'h3);
    chk_val(op_mode, MODE_PIN);
    setp(PIN_MODE, 2'h2);
    chk_val(op_mode, MODE_MASTER);
    report_and_stop();
  end
endmodule
`default_nettype wire
